// [logic/gpct_consts.svh]
// Offsets, field positions, reset values and timing counts of the counter/timer block
`ifndef GPCT_CONSTS_SVH
`define GPCT_CONSTS_SVH
// Register byte offsets; each channel owns a 16-byte window
`define GPCT_CH_STRIDE     8'h10
`define GPCT_OFS_CFG       8'h00
`define GPCT_OFS_TERM      8'h04
`define GPCT_OFS_COUNT     8'h08
`define GPCT_OFS_CTRL      8'h30
`define GPCT_OFS_FDIV      8'h34
`define GPCT_OFS_STAT      8'h38
// Channel configuration fields
`define GPCT_CFG_TGL       0
`define GPCT_CFG_GATE_LSB  1
`define GPCT_CFG_FALL      4
`define GPCT_CFG_SRC_LSB   8
`define GPCT_CFG_MASK      12'hF1F
// Global control fields
`define GPCT_CTRL_ARM_LSB  0
`define GPCT_CTRL_CLR_LSB  4
// Frequency divider fields
`define GPCT_FDIV_EN       0
`define GPCT_FDIV_FALL     1
`define GPCT_FDIV_DIV_LSB  4
`define GPCT_FDIV_SRC_LSB  8
// Reset values
`define GPCT_CFG_RST       12'h000
`define GPCT_TERM_RST      16'hFFFF
`define GPCT_FDIV_RST      12'h000
// Timing
`define GPCT_CLK_HZ        20000000
`define GPCT_BOARD_HZ_J0   10000000
`define GPCT_BOARD_HZ_J1   20000000
`define GPCT_BOARD_DIV     10
`define GPCT_TB_RATIO      10
`define GPCT_TB_NUM        5
`define GPCT_NUM_SRC       14
`endif

// [logic/gpct_pkg.sv]
// Types shared by the counter/timer block
package gpct_pkg;
  typedef enum logic [2:0] {
    GATE_NONE = 3'h0,
    GATE_HI   = 3'h1,
    GATE_LO   = 3'h2,
    GATE_RISE = 3'h3,
    GATE_FALL = 3'h4
  } gpct_gate_t;

  typedef struct packed {
    logic [3:0] src_sel;
    logic [2:0] rsvd;
    logic       src_fall;
    gpct_gate_t gate;
    logic       out_tgl;
  } gpct_cfg_t;
endpackage

// [logic/gpct_ch_if.sv]
// Carrier between the register/source logic and one counter channel
`timescale 1ns/100ps
interface gpct_ch_if;
  gpct_pkg::gpct_cfg_t cfg;
  logic [15:0]         term;
  logic                arm;
  logic                clr;
  logic                src_rise;
  logic                src_fall;
  logic                gate_lvl;
  logic                gate_rise;
  logic                gate_fall;
  logic [15:0]         count;
  logic                out;

  modport ctl (output cfg, term, arm, clr, src_rise, src_fall, gate_lvl, gate_rise,
               gate_fall, input count, out);
  modport chan (input cfg, term, arm, clr, src_rise, src_fall, gate_lvl, gate_rise,
                gate_fall, output count, out);
endinterface

// [logic/gpct_channel.sv]
// One 16-bit counter channel with gating and terminal-count output
`timescale 1ns/100ps
module gpct_channel (
  input  wire logic clk,
  input  wire logic sys_rst,
  gpct_ch_if.chan   ch
);
  logic        act;
  logic        run;
  logic        tc;
  logic        started_r;
  logic [15:0] count_r;
  logic        out_r;

  // Active source edge, falling edge uses the same relations inverted
  // edge polarity select
  assign act = ch.cfg.src_fall ? ch.src_fall : ch.src_rise;

  // Gate is judged at the active source edge only
  // gate versus source edge
  always_comb
  begin
    unique case (ch.cfg.gate)
      gpct_pkg::GATE_NONE: run = ch.arm;
      gpct_pkg::GATE_HI:   run = ch.arm & ch.gate_lvl;
      gpct_pkg::GATE_LO:   run = ch.arm & ~ch.gate_lvl;
      gpct_pkg::GATE_RISE,
      gpct_pkg::GATE_FALL: run = ch.arm & started_r;
      default:             run = 1'b0;  // Codes 5..7 hold the counter
    endcase
  end

  assign tc = run & (count_r == ch.term);

  // Edge gate latch; a gate edge near a source edge may land one period late
  // edge-gated start
  always_ff @(posedge clk)
  begin
    if (sys_rst || ch.clr || !ch.arm)
      started_r <= 1'b0;
    else if ((ch.cfg.gate == gpct_pkg::GATE_RISE && ch.gate_rise) ||
             (ch.cfg.gate == gpct_pkg::GATE_FALL && ch.gate_fall))
      started_r <= 1'b1;
  end

  // Counter wraps to zero after the terminal value
  // count equals gated edges
  always_ff @(posedge clk)
  begin
    if (sys_rst || ch.clr)
      count_r <= 16'h0000;
    else if (act && run)
      count_r <= tc ? 16'h0000 : count_r + 16'h0001;
  end

  // Output moves only on an active source edge or a clear, so a pulse lasts one source period
  // pulse or toggle at terminal count
  always_ff @(posedge clk)
  begin
    if (sys_rst || ch.clr)
      out_r <= 1'b0;
    else if (act)
    begin
      if (ch.cfg.out_tgl)
        out_r <= out_r ^ tc;
      else
        out_r <= tc;
    end
  end

  assign ch.count = count_r;
  assign ch.out   = out_r;
endmodule

// [logic/gpct_top.sv]
// General-purpose counter/timer: three channels, timebases, divider and AXI4-Lite registers
// Functional notes
// - Each counter pulses or toggles its output at every terminal count.
// - Each counter counts rising or falling edges of any source or gate pin.
// - Level gating counts only while the gate sits at its programmed level.
// - Edge gating starts counting after a chosen rising or falling gate edge.
// - Counter outputs feed other counters' sources to form 32- or 48-bit counters.
// - Five internal timebases come from the board clock divided by ten.
// - Gate effect is judged at the active edge of the selected source.
// - Unsynchronised gates act on the nearest or next timebase edge.
// - Every counter output change follows an active source edge; a clear drops the output at once.
// - Falling-edge counting mirrors rising-edge relations on the falling edge.
// - The divider output can be clocked from a source pin.
// - Level-gated timebase count times period equals gate active time.
// - Frequency is the count over a gate window of known length.
// - Channels 1, 2 and 5 are brought out with gate, source and output.
// - Host can read a counter's current value at any time.
`timescale 1ns/100ps
`include "gpct_consts.svh"
module gpct_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [2:0]  gate_pin,
  input  wire logic [2:0]  src_pin,
  input  wire logic        timebase_clock_jumper,
  output logic [2:0]       cnt_out,
  output logic             freq_div_out
);
  // Prescale from clk to the first timebase, board clock over ten: 1 MHz with jumper 0, 2 MHz with jumper 1
  localparam int PRE_J0 = `GPCT_CLK_HZ / (`GPCT_BOARD_HZ_J0 / `GPCT_BOARD_DIV);
  localparam int PRE_J1 = `GPCT_CLK_HZ / (`GPCT_BOARD_HZ_J1 / `GPCT_BOARD_DIV);
  localparam logic [4:0] PRE_J0_MAX = 5'(PRE_J0 - 1);
  localparam logic [4:0] PRE_J1_MAX = 5'(PRE_J1 - 1);
  localparam logic [3:0] TB_MAX     = 4'(`GPCT_TB_RATIO - 1);

  gpct_pkg::gpct_cfg_t    cfg_r [3];
  logic [15:0]            term_r [3];
  logic [2:0]             arm_r;
  logic [2:0]             clr_r;
  logic [11:0]            fdiv_r;
  logic [6:0]             sync1_r;
  logic [6:0]             sync2_r;
  logic [6:0]             prev_r;
  logic [4:0]             pre_r;
  logic [`GPCT_TB_NUM-1:0] tb_tick;
  logic [2:0]             out_prev_r;
  logic [`GPCT_NUM_SRC-1:0] src_rise;
  logic [`GPCT_NUM_SRC-1:0] src_fall;
  logic [15:0]            cnt_val [3];
  logic [2:0]             cnt_lvl;
  logic [3:0]             fdiv_cnt_r;
  logic                   fdiv_out_r;
  logic                   fdiv_act;
  logic [7:0]             aw_addr_r;
  logic                   aw_full_r;
  logic [31:0]            w_data_r;
  logic [3:0]             w_strb_r;
  logic                   w_full_r;
  logic                   bvalid_r;
  logic [1:0]             bresp_r;
  logic                   rvalid_r;
  logic [31:0]            rdata_r;
  logic [1:0]             rresp_r;
  logic                   do_wr;

  // Channel index of an address, 3 when outside the channel windows
  function automatic logic [1:0] chan_of(input logic [7:0] a);
    chan_of = (a < `GPCT_OFS_CTRL) ? a[5:4] : 2'h3;
  endfunction

  // Byte-lane merge of write data into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  // Two flops per pin; gate and source stages start at the pull-up level so reset makes no false edge, the jumper stage at 0
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1_r <= 7'h3F;
      sync2_r <= 7'h3F;
      prev_r  <= 7'h3F;
    end
    else
    begin
      sync1_r <= {timebase_clock_jumper, gate_pin, src_pin};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Prescaler gives the board clock over ten tick, 1 MHz with jumper 0 and 2 MHz with jumper 1
  // board clock divided by ten
  always_ff @(posedge clk)
  begin
    if (sys_rst || pre_r == (sync2_r[6] ? PRE_J1_MAX : PRE_J0_MAX))
      pre_r <= 5'h00;
    else
      pre_r <= pre_r + 5'h01;
  end
  assign tb_tick[0] = (pre_r == 5'h00);

  // Decade chain for the slower timebases
  // five timebases
  generate
    for (genvar t = 1; t < `GPCT_TB_NUM; t++)
    begin : g_tb
      logic [3:0] dec_r;
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          dec_r <= 4'h0;
        else if (tb_tick[t-1])
          dec_r <= (dec_r == TB_MAX) ? 4'h0 : dec_r + 4'h1;
      end
      assign tb_tick[t] = tb_tick[t-1] && (dec_r == TB_MAX);
    end
  endgenerate

  // Counter outputs are same-clock signals, so edges need no synchroniser
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      out_prev_r <= 3'h0;
    else
      out_prev_r <= cnt_lvl;
  end

  // Source list: 0-2 source pins, 3-5 gate pins, 6-10 timebases, 11-13 counter outputs
  // any source or gate pin
  assign src_rise = {cnt_lvl & ~out_prev_r, tb_tick, sync2_r[5:0] & ~prev_r[5:0]};
  assign src_fall = {~cnt_lvl & out_prev_r, tb_tick, ~sync2_r[5:0] & prev_r[5:0]};

  // Channels 1, 2 and 5 sit at indices 0, 1 and 2
  // three channels brought out
  gpct_ch_if ch_if [3] ();
  generate
    for (genvar c = 0; c < 3; c++)
    begin : g_ch
      logic [`GPCT_NUM_SRC-1:0] sel;
      assign sel = `GPCT_NUM_SRC'(1) << cfg_r[c].src_sel;
      assign ch_if[c].cfg       = cfg_r[c];
      assign ch_if[c].term      = term_r[c];
      assign ch_if[c].arm       = arm_r[c];
      assign ch_if[c].clr       = clr_r[c];
      assign ch_if[c].src_rise  = |(src_rise & sel);
      assign ch_if[c].src_fall  = |(src_fall & sel);
      assign ch_if[c].gate_lvl  = sync2_r[3+c];
      assign ch_if[c].gate_rise = src_rise[3+c];
      assign ch_if[c].gate_fall = src_fall[3+c];
      assign cnt_val[c]         = ch_if[c].count;
      assign cnt_lvl[c]         = ch_if[c].out;
      gpct_channel u_ch (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ch      (ch_if[c])
      );
    end
  endgenerate
  assign cnt_out = cnt_lvl;

  // Divider toggles its output every div+1 active edges of its chosen source
  // divider from source pin
  assign fdiv_act = fdiv_r[`GPCT_FDIV_FALL] ? src_fall[fdiv_r[`GPCT_FDIV_SRC_LSB +: 4]]
                                            : src_rise[fdiv_r[`GPCT_FDIV_SRC_LSB +: 4]];
  always_ff @(posedge clk)
  begin
    if (sys_rst || !fdiv_r[`GPCT_FDIV_EN])
    begin
      fdiv_cnt_r <= 4'h0;
      fdiv_out_r <= 1'b0;
    end
    else if (fdiv_act)
    begin
      if (fdiv_cnt_r == fdiv_r[`GPCT_FDIV_DIV_LSB +: 4])
      begin
        fdiv_cnt_r <= 4'h0;
        fdiv_out_r <= ~fdiv_out_r;
      end
      else
        fdiv_cnt_r <= fdiv_cnt_r + 4'h1;
    end
  end
  assign freq_div_out = fdiv_out_r;

  // Address and data are held independently; the write fires once both are in
  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready  = ~w_full_r;
  assign do_wr         = aw_full_r & w_full_r & ~bvalid_r;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_r)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      else if (do_wr)
        aw_full_r <= 1'b0;
      if (s_axi_wvalid && !w_full_r)
      begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      else if (do_wr)
        w_full_r <= 1'b0;
    end
  end

  // Write response; unmapped offsets answer SLVERR and change nothing
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= 2'h0;
    end
    else if (do_wr)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= (aw_addr_r[1:0] != 2'h0 || aw_addr_r > `GPCT_OFS_STAT ||
                   (chan_of(aw_addr_r) != 2'h3 && aw_addr_r[3:2] > 2'h1)) ? 2'h2 : 2'h0;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // Configuration holds until software rewrites it
  // held mode settings
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int c = 0; c < 3; c++)
      begin
        cfg_r[c]  <= gpct_pkg::gpct_cfg_t'(`GPCT_CFG_RST);
        term_r[c] <= `GPCT_TERM_RST;
      end
      arm_r  <= 3'h0;
      fdiv_r <= `GPCT_FDIV_RST;
    end
    else if (do_wr && aw_addr_r[1:0] == 2'h0)
    begin
      if (chan_of(aw_addr_r) != 2'h3)
      begin
        if (aw_addr_r[3:0] == 4'(`GPCT_OFS_CFG))
          cfg_r[chan_of(aw_addr_r)] <= gpct_pkg::gpct_cfg_t'(`GPCT_CFG_MASK &
            12'(merge(32'(cfg_r[chan_of(aw_addr_r)]), w_data_r, w_strb_r)));
        else if (aw_addr_r[3:0] == 4'(`GPCT_OFS_TERM))
          term_r[chan_of(aw_addr_r)] <=
            16'(merge(32'(term_r[chan_of(aw_addr_r)]), w_data_r, w_strb_r));
      end
      else if (aw_addr_r == `GPCT_OFS_CTRL && w_strb_r[0])
        arm_r <= w_data_r[`GPCT_CTRL_ARM_LSB +: 3];
      else if (aw_addr_r == `GPCT_OFS_FDIV)
        fdiv_r <= 12'(merge(32'(fdiv_r), w_data_r, w_strb_r));
    end
  end

  // Clear bits are write-one strobes lasting one cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      clr_r <= 3'h0;
    else if (do_wr && aw_addr_r == `GPCT_OFS_CTRL && w_strb_r[0])
      clr_r <= w_data_r[`GPCT_CTRL_CLR_LSB +: 3];
    else
      clr_r <= 3'h0;
  end

  // Read path; the count is live, so software sees it mid-run without stopping it
  // live count read-back
  assign s_axi_arready = ~rvalid_r;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= 2'h0;
    end
    else if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= 2'h0;
      rdata_r  <= 32'h0000_0000;
      if (s_axi_araddr[1:0] != 2'h0)
        rresp_r <= 2'h2;
      else if (chan_of(s_axi_araddr) != 2'h3)
      begin
        unique case (s_axi_araddr[3:0])
          4'(`GPCT_OFS_CFG):   rdata_r <= 32'(cfg_r[chan_of(s_axi_araddr)]);
          4'(`GPCT_OFS_TERM):  rdata_r <= 32'(term_r[chan_of(s_axi_araddr)]);
          4'(`GPCT_OFS_COUNT): rdata_r <= 32'(cnt_val[chan_of(s_axi_araddr)]);
          default:         rresp_r <= 2'h2;
        endcase
      end
      else if (s_axi_araddr == `GPCT_OFS_CTRL)
        rdata_r <= 32'(arm_r);
      else if (s_axi_araddr == `GPCT_OFS_FDIV)
        rdata_r <= 32'(fdiv_r);
      else if (s_axi_araddr == `GPCT_OFS_STAT)
        rdata_r <= {25'h0, fdiv_out_r, sync2_r[5:3], cnt_lvl};
      else
        rresp_r <= 2'h2;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;
endmodule

// [test/gpct_top_sva.sv]
// Bus handshake checks on the counter/timer top ports
`timescale 1ns/100ps
module gpct_top_sva (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [2:0]  cnt_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Answers stand until the master takes them
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer changed before taken");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=>
                     s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed before taken");
  read_block_a:
    assert property (s_axi_arready != s_axi_rvalid)
    else $error("read address ready while answer pending");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  bresp_done_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  rdata_done_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  rdata_width_a:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  slverr_zero_a:
    assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");

  // Main scenarios reached
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property ($rose(cnt_out[0]));
endmodule

// [test/gpct_field_model.sv]
// Field side: pulse bursts on source pins, switch levels on gate pins
`timescale 1ns/100ps
module gpct_field_model #(
  parameter int HALF = 4
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       go,
  input  wire logic [1:0] ch,
  input  wire logic [7:0] n,
  input  wire logic [2:0] gate_set,
  output logic [2:0]      src_pin,
  output logic [2:0]      gate_pin,
  output logic            busy
);
  logic [7:0] left_r;
  logic [7:0] ph_r;
  logic [1:0] sel_r;

  // Switches follow the bench levels directly
  assign gate_pin = gate_set;

  // source rate limit
  // Low then high for HALF clocks each; idle high as the pull-up leaves it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      busy    <= 1'b0;
      src_pin <= 3'h7;
      left_r  <= 8'h00;
      ph_r    <= 8'h00;
      sel_r   <= 2'h0;
    end
    else if (go && !busy)
    begin
      busy   <= 1'b1;
      left_r <= n;
      sel_r  <= ch;
      ph_r   <= 8'h00;
    end
    else if (busy)
    begin
      src_pin[sel_r] <= (ph_r >= HALF);
      ph_r <= (ph_r == 2 * HALF - 1) ? 8'h00 : ph_r + 8'h01;
      if (ph_r == 2 * HALF - 1)
      begin
        left_r <= left_r - 8'h01;
        busy   <= (left_r != 8'h01);
      end
    end
  end
endmodule

// [test/tb_top.sv]
// Self-checking bench: register traffic over AXI4-Lite plus field bursts
`timescale 1ns/100ps
module tb_top;
  logic        clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, timebase_clock_jumper, freq_div_out, go, busy;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, n;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, ch;
  logic [2:0]  gate_pin, src_pin, cnt_out, gate_set;
  logic        idle;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  gpct_top gpct_top_i (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gate_pin, .src_pin,
    .timebase_clock_jumper, .cnt_out, .freq_div_out);
  gpct_field_model gpct_field_model_i (.clk, .sys_rst, .go, .ch, .n, .gate_set, .src_pin,
    .gate_pin, .busy);

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard, far above the roughly one thousand cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      failures++;
      $display("unexpected at %0t: run hung", $time);
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s response %h want %h", $time, m, got, exp);
    end
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk_resp(r, 2'h0, "write");
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk_resp(rd_r, 2'h0, "read");
    chk_data(rd_d, exp, "read value");
  endtask

  // Burst of k pulses on one source pin, then time for the pin synchronisers
  task automatic burst(input logic [1:0] c, input logic [7:0] k);
    @(posedge clk);
    ch <= c;
    n  <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (busy);
    repeat (6) @(posedge clk);
  endtask

  function automatic logic [31:0] cfgv(input logic [3:0] s, input logic f,
                                       input gpct_pkg::gpct_gate_t g, input logic t);
    return {20'h0, s, 3'h0, f, g, t};
  endfunction

  // Main sequence; jumper at 20 MHz board clock halves timebase periods
  initial
  begin
    {sys_rst, go, idle} = 3'h4;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, n, ch, gate_set} = 29'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    timebase_clock_jumper = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rreg(8'h00, 32'h0);
    rreg(8'h04, 32'hFFFF);
    rd(8'h3C);
    chk_resp(rd_r, 2'h2, "unmapped read");
    wr(8'h08, 32'h5, rd_r);
    chk_resp(rd_r, 2'h2, "count write");
    $display("test reset done");
    wreg(8'h30, 32'h7);
    wreg(8'h10, cfgv(4'h1, 1'b1, gpct_pkg::GATE_NONE, 1'b0));
    burst(2'h0, 8'h05);
    burst(2'h1, 8'h05);
    rreg(8'h08, 32'h5);
    rreg(8'h18, 32'h5);
    $display("test edges done");
    // Every gating mode: held off while inactive, counts once activated
    for (int m = 1; m < 5; m++)
    begin
      idle = (m == 2 || m == 4);
      gate_set[0] <= idle;
      wreg(8'h00, cfgv(4'h0, 1'b0, gpct_pkg::gpct_gate_t'(m), 1'b0));
      wreg(8'h30, 32'h77);
      burst(2'h0, 8'h03);
      rreg(8'h08, 32'h0);
      gate_set[0] <= ~idle;
      burst(2'h0, 8'h04);
      rreg(8'h08, 32'h4);
    end
    $display("test gating done");
    // Pulse then toggle output at a terminal value of 2
    for (int t = 0; t < 2; t++)
    begin
      wreg(8'h00, cfgv(4'h0, 1'b0, gpct_pkg::GATE_NONE, t[0]));
      wreg(8'h04, 32'h2);
      wreg(8'h30, 32'h77);
      burst(2'h0, 8'h03);
      chk_data({31'h0, cnt_out[0]}, 32'h1, "terminal output");
      rreg(8'h08, 32'h0);
      burst(2'h0, 8'h01);
      chk_data({31'h0, cnt_out[0]}, t, "output after next edge");
    end
    $display("test terminal done");
    wreg(8'h00, cfgv(4'h0, 1'b0, gpct_pkg::GATE_NONE, 1'b1));
    wreg(8'h04, 32'h1);
    wreg(8'h10, cfgv(4'hB, 1'b0, gpct_pkg::GATE_NONE, 1'b0));
    wreg(8'h30, 32'h77);
    rreg(8'h30, 32'h7);
    burst(2'h0, 8'h04);
    rreg(8'h18, 32'h1);
    $display("test cascade done");
    wreg(8'h20, cfgv(4'h6, 1'b0, gpct_pkg::GATE_HI, 1'b0));
    wreg(8'h30, 32'h77);
    gate_set[2] <= 1'b1;
    repeat (200) @(posedge clk);
    gate_set[2] <= 1'b0;
    repeat (30) @(posedge clk);
    rd(8'h28);
    // 200 clocks at 10 clocks a tick, one tick of gate uncertainty either way
    chk_data({31'h0, rd_d >= 19 && rd_d <= 21}, 32'h1, "timebase count");
    $display("test timebase done");
    wreg(8'h34, 32'h011);
    burst(2'h0, 8'h02);
    chk_data({31'h0, freq_div_out}, 32'h1, "divider output");
    // Divider high and channel 1 toggled high by its terminal count
    rreg(8'h38, 32'h41);
    burst(2'h0, 8'h02);
    chk_data({31'h0, freq_div_out}, 32'h0, "divider output");
    $display("test divider done");
    summarize();
  end
endmodule

bind gpct_top gpct_top_sva gpct_top_sva_i (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cnt_out);
